// *** core/l2_irq_pkg.sv ***
package l2_irq_pkg;

    // Queue topology
    localparam int          NUM_QUEUES    = 9;
    localparam int          GEN_QUEUES    = 8;
    localparam logic [3:0]  CMD_QUEUE     = 4'h8;
    localparam logic [15:0] CMD_QUEUE_LEN = 16'h0200;  // Two halves of 256 DWORDs

    // Vector group encodings
    localparam logic [1:0]  GRP_CMD  = 2'h0;
    localparam logic [1:0]  GRP_CHAN = 2'h1;
    localparam logic [1:0]  GRP_PORT = 2'h2;
    localparam logic [1:0]  GRP_SYS  = 2'h3;
    localparam logic [1:0]  SUB_SYS  = 2'h0;
    localparam int          SUB_DIR_BIT = 1;            // Upper subclass bit: transmit or receive path

    // System flag positions inside the 5-bit flag group (payload bits 20:16)
    localparam int          SYS_FLAGS      = 5;
    localparam int          FLAG_MAILBOX   = 4;
    localparam int          FLAG_RX_FAIL   = 3;
    localparam int          FLAG_RX_EARLY  = 2;
    localparam int          FLAG_ACT_EARLY = 1;
    localparam int          FLAG_LANE_ERR  = 0;
    localparam logic [3:0]  BYTE_LANES_ALL = 4'hF;

    // Write engine states
    typedef enum logic [0:0] {
        ST_IDLE  = 1'b0,
        ST_WRITE = 1'b1
    } wr_state_t;

    // Vector layout: valid mark, group, subclass, ring, payload
    function automatic logic [31:0] makeVector(
        input logic [1:0]  grp,
        input logic [1:0]  sub,
        input logic [2:0]  ring,
        input logic [23:0] payload
    );
        makeVector = {1'b1, grp, sub, ring, payload};
    endfunction

    // Command vectors are steered only into the fixed command queue
    function automatic logic [3:0] targetQueue(
        input logic [1:0] grp,
        input logic [2:0] ring
    );
        targetQueue = (grp == GRP_CMD) ? CMD_QUEUE : {1'b0, ring};
    endfunction

endpackage

// *** core/sys_event_collector.sv ***
`timescale 1ns/1ps
module sys_event_collector (
    input  wire logic                              clock,        // System clock
    input  wire logic                              rst,          // Async reset, high
    input  wire logic                              sysEnable,    // System sources unmasked
    input  wire logic                              mailboxDoorbellFlag,   // Mailbox written, pulse
    input  wire logic                              rxBufferAccessFailed,  // Rx buffer fail, pulse
    input  wire logic                              rxQueueEarlyWarning,   // Rx queue warning, pulse
    input  wire logic                              rxActionEarlyWarning,  // Action queue warning, pulse
    input  wire logic                              regAccess,    // Internal register access, pulse
    input  wire logic [3:0]                        regByteLanes, // Lanes enabled on that access
    input  wire logic                              take,         // Engine consumed pending flags
    output logic [l2_irq_pkg::SYS_FLAGS-1:0]       pending,      // Collected flags, registered
    output logic                                   pendingValid  // Any flag pending, registered
);

    typedef struct packed {
        logic [l2_irq_pkg::SYS_FLAGS-1:0] flags;
        logic                             valid;
    } coll_state_t;

    coll_state_t s_q;
    coll_state_t s_d;
    logic [l2_irq_pkg::SYS_FLAGS-1:0] newEv;

    // Merge fresh events; a new event beats the clear from take
    always_comb
    begin
        newEv = '0;
        newEv[l2_irq_pkg::FLAG_MAILBOX]   = mailboxDoorbellFlag;
        newEv[l2_irq_pkg::FLAG_RX_FAIL]   = rxBufferAccessFailed;
        newEv[l2_irq_pkg::FLAG_RX_EARLY]  = rxQueueEarlyWarning;
        newEv[l2_irq_pkg::FLAG_ACT_EARLY] = rxActionEarlyWarning;
        newEv[l2_irq_pkg::FLAG_LANE_ERR]  = regAccess && (regByteLanes != l2_irq_pkg::BYTE_LANES_ALL);
        if (!sysEnable)
        begin
            newEv = '0;
        end
        s_d = s_q;
        s_d.flags = (take ? '0 : s_q.flags) | newEv;
        s_d.valid = |s_d.flags;
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign pending      = s_q.flags;
    assign pendingValid = s_q.valid;

endmodule

// *** core/layer_two_interrupt_queue_writer.sv ***
`timescale 1ns/1ps
// Functional notes
// - After a vector is stored in any of the nine queues the PCI interrupt line is raised.
// - A global status register shows which queue holds a newly written vector.
// - Each queue has a mask that keeps the line low but still lets the vector be stored.
// - Queues live in external system memory and are filled by bus writes from this block.
// - Eight general queues are rings, each with its own start address and size.
// - A separate command queue of fixed size two times 256 DWORDs holds only command vectors.
// - Nine start addresses and eight lengths configure the queues; queue 8 has a fixed length.
// - Vectors are 32 bits: group 30:29, subclass 28:27, target ring 26:24, payload 23:0.
// - Bit 31 is always written as one so the host can clear it to mark a vector done.
// - Groups encode 00 command, 01 channel, 10 port, 11 system.
// - The upper subclass bit tells transmit from receive path.
// - The payload meaning depends on group and subclass together.
// - The target ring field names the queue the vector is written into; command vectors go to queue 8 whatever the ring field holds.
// - After reset no vector is made; system sources stay masked until enabled.
module layer_two_interrupt_queue_writer (
    input  wire logic                                clock,           // System clock, 10 MHz
    input  wire logic                                rst,             // Async reset, high
    // Vector sources (channel, port, command)
    input  wire logic                                srcValid,        // Vector offered
    input  wire logic [1:0]                          srcGroup,        // Vector group
    input  wire logic [1:0]                          srcSubclass,     // Vector subclass
    input  wire logic [2:0]                          srcRing,         // Target ring
    input  wire logic [23:0]                         srcPayload,      // Group specific payload
    output logic                                     srcReady,        // Offer taken when high
    // System event sources
    input  wire logic                                sysEnable,       // Unmasks system events
    input  wire logic [2:0]                          sysRing,         // Ring for system vectors
    input  wire logic [15:0]                         systemDetailField, // Detail for system vectors
    input  wire logic                                mailboxDoorbellFlag,   // Event pulse
    input  wire logic                                rxBufferAccessFailed,  // Event pulse
    input  wire logic                                rxQueueEarlyWarning,   // Event pulse
    input  wire logic                                rxActionEarlyWarning,  // Event pulse
    input  wire logic                                regAccess,       // Register access pulse
    input  wire logic [3:0]                          regByteLanes,    // Byte lanes of that access
    // Queue configuration
    input  wire logic [l2_irq_pkg::NUM_QUEUES-1:0][31:0] queueStart,  // Byte start per queue
    input  wire logic [l2_irq_pkg::GEN_QUEUES-1:0][15:0] queueLength, // DWORD size, general queues
    input  wire logic [l2_irq_pkg::NUM_QUEUES-1:0]   queueMask,       // High masks the line
    input  wire logic [l2_irq_pkg::NUM_QUEUES-1:0]   statusAck,       // Write-one-clear pulse
    // Memory write master
    output logic                                     memWrValid,      // Write request
    output logic [31:0]                              memWrAddr,       // Byte address
    output logic [31:0]                              memWrData,       // Vector word
    input  wire logic                                memWrReady,      // Write accepted
    // Host notification
    output logic [l2_irq_pkg::NUM_QUEUES-1:0]        globalStatus,    // Queues with new vectors
    output logic                                     intaLine         // PCI interrupt, high active
);

    // Whole engine state in one record, registered by a single process
    typedef struct packed {
        l2_irq_pkg::wr_state_t                         state;
        logic [l2_irq_pkg::NUM_QUEUES-1:0][15:0]       wrPtr;
        logic [3:0]                                    curQueue;
        logic [31:0]                                   addr;
        logic [31:0]                                   data;
        logic                                          memValid;
        logic [l2_irq_pkg::NUM_QUEUES-1:0]             status;
        logic                                          inta;
        logic                                          ready;
    } wr_engine_t;

    // Current state and its next value
    wr_engine_t s_q;
    wr_engine_t s_d;

    // Handshake with the event collector
    logic [l2_irq_pkg::SYS_FLAGS-1:0] sysFlags;
    logic                             sysValid;
    logic                             sysTake;

    // Sticky collection of system events
    sys_event_collector events (
        .clock                (clock),
        .rst                  (rst),
        .sysEnable            (sysEnable),
        .mailboxDoorbellFlag  (mailboxDoorbellFlag),
        .rxBufferAccessFailed (rxBufferAccessFailed),
        .rxQueueEarlyWarning  (rxQueueEarlyWarning),
        .rxActionEarlyWarning (rxActionEarlyWarning),
        .regAccess            (regAccess),
        .regByteLanes         (regByteLanes),
        .take                 (sysTake),
        .pending              (sysFlags),
        .pendingValid         (sysValid)
    );

    // Ring length of a queue; the command queue is fixed
    function automatic logic [15:0] ringLen(
        input logic [3:0] q
    );
        if (q == l2_irq_pkg::CMD_QUEUE)
        begin
            ringLen = l2_irq_pkg::CMD_QUEUE_LEN;
        end
        else
        begin
            ringLen = queueLength[q[2:0]];
        end
    endfunction

    // Load a vector into the engine and point at the next ring slot
    function automatic wr_engine_t launch(
        input wr_engine_t s,
        input logic [3:0] q,
        input logic [31:0] vec
    );
        wr_engine_t r;
        r = s;
        r.state    = l2_irq_pkg::ST_WRITE;
        r.curQueue = q;
        r.data     = vec;
        // DWORD pointer becomes a byte offset from the ring start
        r.addr     = queueStart[q] + {14'h0000, s.wrPtr[q], 2'h0};
        r.memValid = 1'b1;
        r.ready    = 1'b0;
        launch     = r;
    endfunction

    // Helpers, given a value at the top of the engine process
    logic [15:0] nextPtr;
    logic [23:0] sysPayload;
    logic        srcTake;

    // Engine: sources are served one at a time; a held offer is taken before system events
    always_comb
    begin
        s_d        = s_q;
        sysTake    = 1'b0;
        srcTake    = srcValid && s_q.ready;
        nextPtr    = s_q.wrPtr[s_q.curQueue] + 16'h0001;
        sysPayload = {3'h0, sysFlags, systemDetailField};
        case (s_q.state)
            l2_irq_pkg::ST_IDLE:
            begin
                // Ready rises one cycle after reset or a finished write, never while busy
                if (srcTake)
                begin
                    // Ring field and payload pass unchanged; meaning rides on group and subclass
                    s_d = launch(s_q, l2_irq_pkg::targetQueue(srcGroup, srcRing),
                                 l2_irq_pkg::makeVector(srcGroup, srcSubclass,
                                                        srcRing, srcPayload));
                end
                else if (sysValid)
                begin
                    // Collector cleared here; a flag arriving now stays for the next vector
                    sysTake = 1'b1;
                    s_d = launch(s_q, {1'b0, sysRing},
                                 l2_irq_pkg::makeVector(l2_irq_pkg::GRP_SYS, l2_irq_pkg::SUB_SYS,
                                                        sysRing, sysPayload));
                end
                else
                begin
                    s_d.ready = 1'b1;
                end
            end
            l2_irq_pkg::ST_WRITE:
            begin
                // Address and data stand unchanged while the memory stalls
                if (memWrReady)
                begin
                    // Wrap at the programmed size; a zero size acts as one slot
                    // No overflow check: the host must drain a ring before the pointer laps unread words
                    if (nextPtr >= ringLen(s_q.curQueue))
                    begin
                        s_d.wrPtr[s_q.curQueue] = 16'h0000;
                    end
                    else
                    begin
                        s_d.wrPtr[s_q.curQueue] = nextPtr;
                    end
                    s_d.memValid = 1'b0;
                    s_d.state    = l2_irq_pkg::ST_IDLE;
                    s_d.ready    = 1'b1;
                end
            end
            // Unused code: back to idle, no write left pending
            default:
            begin
                s_d.state    = l2_irq_pkg::ST_IDLE;
                s_d.memValid = 1'b0;
            end
        endcase

        // Status: the stored vector's bit wins over a same-cycle acknowledge
        s_d.status = s_q.status & ~statusAck;
        if (s_q.state == l2_irq_pkg::ST_WRITE && memWrReady)
        begin
            s_d.status[s_q.curQueue] = 1'b1;
        end
        // Masked queues still store and flag, but keep the line low
        s_d.inta = |(s_d.status & ~queueMask);
    end

    // Single register stage; engine is idle and nothing flagged after reset
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            s_q       <= '0;
            s_q.state <= l2_irq_pkg::ST_IDLE;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Outputs taken straight from the register stage
    assign srcReady     = s_q.ready;
    assign memWrValid   = s_q.memValid;
    assign memWrAddr    = s_q.addr;
    assign memWrData    = s_q.data;
    assign globalStatus = s_q.status;
    assign intaLine     = s_q.inta;

endmodule

// *** bench/l2_irq_props.sv ***
`timescale 1ns/1ps
module l2_irq_props (
    input wire logic        clock,        // Clock
    input wire logic        rst,          // Reset
    input wire logic        srcValid,     // Offer
    input wire logic [1:0]  srcGroup,     // Group
    input wire logic [1:0]  srcSubclass,  // Subclass
    input wire logic [2:0]  srcRing,      // Ring
    input wire logic [23:0] srcPayload,   // Payload
    input wire logic        srcReady,     // Taken
    input wire logic        sysEnable,    // System unmask
    input wire logic        regAccess,    // Access pulse
    input wire logic [3:0]  regByteLanes, // Lanes
    input wire logic [8:0]  queueMask,    // Masks
    input wire logic [8:0]  statusAck,    // Acks
    input wire logic        memWrValid,   // Write
    input wire logic [31:0] memWrData,    // Word
    input wire logic        memWrReady,   // Accept
    input wire logic [8:0]  globalStatus, // Status
    input wire logic        intaLine      // Interrupt
);
    logic [3:0] wq;
    logic       acc;
    // Queue of the word on the bus; command words always land in queue 8
    assign wq  = (memWrData[30:29] == 2'h0) ? 4'h8 : {1'h0, memWrData[26:24]};
    assign acc = memWrValid && memWrReady;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    chk_mark_set: assert property (memWrValid |-> memWrData[31])
        else $error("vector written without top bit");
    chk_write_hold: assert property (memWrValid && !memWrReady |=> memWrValid && $stable(memWrData))
        else $error("write dropped or changed before accept");
    chk_take_word: assert property (srcValid && srcReady |=> memWrValid && !srcReady
        && memWrData[30:0] == {$past(srcGroup), $past(srcSubclass), $past(srcRing), $past(srcPayload)})
        else $error("taken offer not written as laid out");
    chk_status_set: assert property (acc |=> globalStatus[$past(wq)])
        else $error("status bit missing after write");
    chk_inta_follow: assert property ($stable(queueMask) |-> intaLine == |(globalStatus & ~queueMask))
        else $error("interrupt line disagrees with unmasked status");
    chk_ack_clear: assert property (statusAck != 9'h000 && !acc |=> (globalStatus & $past(statusAck)) == 9'h000)
        else $error("acknowledged status bit still set");
    // Quiet window keeps an older pending vector from taking the slot
    chk_lane_error: assert property ((regAccess && sysEnable && regByteLanes != 4'hF && !memWrValid && !srcValid)
        ##1 (!srcValid && !memWrValid) |=> memWrValid && memWrData[30:27] == 4'hC && memWrData[16])
        else $error("partial lane access gave no system vector");
    chk_reset_quiet: assert property ($fell(rst) |-> !memWrValid && globalStatus == 9'h000 && !intaLine)
        else $error("activity right after reset");
    cover property (acc && wq == 4'h8);
    cover property (acc && memWrData[30:29] == 2'h3);
    cover property (acc ##1 (!intaLine && globalStatus != 9'h000));
endmodule
bind layer_two_interrupt_queue_writer l2_irq_props chk (.clock, .rst, .srcValid, .srcGroup, .srcSubclass, .srcRing,
    .srcPayload, .srcReady, .sysEnable, .regAccess, .regByteLanes, .queueMask, .statusAck, .memWrValid,
    .memWrData, .memWrReady, .globalStatus, .intaLine);

// *** bench/host_mem_model.sv ***
`timescale 1ns/1ps
module host_mem_model (
    input wire logic        clock,      // Clock
    input wire logic        rst,        // Reset
    input wire logic        slow,       // Stall each write
    input wire logic        memWrValid, // Write request
    input wire logic [31:0] memWrAddr,  // Byte address
    input wire logic [31:0] memWrData,  // Vector word
    output logic            memWrReady, // Accept
    output logic [31:0]     lastAddr,   // Last address stored
    output logic [31:0]     lastData,   // Last word stored
    output logic [7:0]      writes      // Words stored
);
    logic [1:0] waitQ;
    // Shared memory takes words at once, or after two stall cycles
    assign memWrReady = memWrValid && (!slow || waitQ == 2'h2);
    // Store the word as written; host never clears the top bit here
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            waitQ <= 2'h0;
            writes <= 8'h00;
        end
        else if (memWrReady)
        begin
            waitQ <= 2'h0;
            lastAddr <= memWrAddr;
            lastData <= memWrData;
            writes <= writes + 8'h01;
        end
        else if (memWrValid)
        begin
            waitQ <= waitQ + 2'h1;
        end
    end
endmodule

// *** bench/layer_two_interrupt_queue_writer_test.sv ***
`timescale 1ns/1ps
module layer_two_interrupt_queue_writer_test;
    logic             clock, rst, srcValid, srcReady, sysEnable, memWrValid, memWrReady, intaLine, slow;
    logic [1:0]       srcGroup, srcSubclass;
    logic [2:0]       srcRing, sysRing;
    logic [23:0]      srcPayload;
    logic [15:0]      detail;
    logic [4:0]       evt;
    logic [3:0]       lanes;
    logic [8:0][31:0] queueStart;
    logic [7:0][15:0] queueLength;
    logic [8:0]       queueMask, statusAck, globalStatus, expSt;
    logic [31:0]      memWrAddr, memWrData, lastAddr, lastData;
    logic [7:0]       writes;
    int               miscompares, compares, cycles;
    int               ptr [9];

    layer_two_interrupt_queue_writer dut (.clock, .rst, .srcValid, .srcGroup, .srcSubclass, .srcRing, .srcPayload,
        .srcReady, .sysEnable, .sysRing, .systemDetailField(detail), .mailboxDoorbellFlag(evt[4]),
        .rxBufferAccessFailed(evt[3]), .rxQueueEarlyWarning(evt[2]), .rxActionEarlyWarning(evt[1]),
        .regAccess(evt[0]), .regByteLanes(lanes), .queueStart, .queueLength, .queueMask, .statusAck,
        .memWrValid, .memWrAddr, .memWrData, .memWrReady, .globalStatus, .intaLine);
    host_mem_model mem (.clock, .rst, .slow, .memWrValid, .memWrAddr, .memWrData, .memWrReady, .lastAddr,
        .lastData, .writes);

    initial
    begin
        clock = 0;
        forever #50 clock = ~clock;
    end
    // Hang guard: all tests fit well inside this many cycles
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            miscompares++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
        end
    endtask
    task automatic check_bit(input logic got, input logic exp);
        check_word({31'h0, got}, {31'h0, exp});
    endtask
    // Waits for write n, then checks where it landed and what it raised
    task automatic stored(input logic [7:0] n, input int q, input logic [31:0] d);
        int i;
        int len;
        len = (q == 8) ? 512 : int'(queueLength[q]);
        for (i = 0; i < 20 && writes !== n; i++) @(negedge clock);
        check_word({24'h0, writes}, {24'h0, n});
        check_word(lastAddr, queueStart[q] + 32'(4 * ptr[q]));
        check_word(lastData, d);
        expSt[q] = 1'h1;
        check_word({23'h0, globalStatus}, {23'h0, expSt});
        check_bit(intaLine, |(expSt & ~queueMask));
        ptr[q] = (ptr[q] + 1 >= len) ? 0 : ptr[q] + 1;
    endtask
    task automatic send(input logic [1:0] g, input logic [1:0] s, input logic [2:0] r, input logic [23:0] p);
        int i;
        logic [7:0] n;
        n = writes + 8'h01;
        {srcGroup, srcSubclass, srcRing, srcPayload} = {g, s, r, p};
        srcValid = 1;
        for (i = 0; i < 20 && srcReady !== 1'h1; i++) @(negedge clock);
        @(negedge clock);
        srcValid = 0;
        stored(n, (g == 2'h0) ? 8 : int'(r), {1'h1, g, s, r, p});
    endtask
    task automatic ack(input logic [8:0] m);
        statusAck = m;
        @(negedge clock);
        statusAck = 9'h000;
        expSt = expSt & ~m;
        check_word({23'h0, globalStatus}, {23'h0, expSt});
    endtask
    // Every group, command words steered to queue 8
    task automatic t_groups();
        for (int g = 0; g < 4; g++) send(2'(g), 2'(g), 3'(g + 1), 24'h5A0000 + 24'(g));
        ack(9'h1FF);
        $display("test groups done");
    endtask
    // Two-entry ring wraps while the memory stalls
    task automatic t_ring();
        slow = 1;
        queueLength[2] = 16'h0002;
        repeat (3) send(2'h1, 2'h0, 3'h2, 24'h00C0DE);
        slow = 0;
        ack(9'h004);
        $display("test ring done");
    endtask
    task automatic t_mask();
        queueMask = 9'h008;
        send(2'h2, 2'h0, 3'h3, 24'h000011);
        send(2'h2, 2'h2, 3'h4, 24'h000012);
        ack(9'h010);
        check_bit(intaLine, 1'h0);
        queueMask = 9'h000;
        @(negedge clock);
        check_bit(intaLine, 1'h1);
        ack(9'h008);
        check_bit(intaLine, 1'h0);
        $display("test mask done");
    endtask
    // Each system flag alone, then a full-lane access and a doorbell with system sources disabled, both silent
    task automatic t_sys();
        logic [7:0] n;
        sysEnable = 1;
        for (int i = 0; i < 5; i++)
        begin
            n = writes + 8'h01;
            evt = 5'h01 << i;
            @(negedge clock);
            evt = 5'h00;
            stored(n, 5, {1'h1, 2'h3, 2'h0, 3'h5, 3'h0, 5'h01 << i, detail});
        end
        n = writes;
        lanes = 4'hF;
        evt = 5'h01;
        @(negedge clock);
        sysEnable = 0;
        evt = 5'h10;
        @(negedge clock);
        evt = 5'h00;
        repeat (6) @(negedge clock);
        check_word({24'h0, writes}, {24'h0, n});
        $display("test system done");
    endtask

    initial
    begin
        rst = 1'h1;
        {slow, srcValid, sysEnable, srcGroup, srcSubclass, srcRing, srcPayload, evt} = '0;
        {sysRing, detail, lanes, queueMask, statusAck, expSt} = {3'h5, 16'hA5C3, 4'h3, 27'h0};
        for (int i = 0; i < 9; i++) queueStart[i] = 32'(i + 1) << 16;
        for (int i = 0; i < 8; i++) queueLength[i] = 16'h0004;
        repeat (3) @(negedge clock);
        rst = 0;
        @(negedge clock);
        check_word({22'h0, memWrValid, globalStatus}, 32'h0);
        check_bit(intaLine, 1'h0);
        t_groups();
        t_ring();
        t_mask();
        t_sys();
        complete_run();
    end
endmodule
